/* logic/bow_pkg.sv */
// Types shared by the breaker object control and wear monitor
package bow_pkg;
  // ==========================================================
  // Command sequencer states
  typedef enum logic [3:0] {
    CS_IDLE = 4'h1,
    CS_OPEN = 4'h2,
    CS_CLOSE = 4'h4,
    CS_WAIT = 4'h8
  } bow_cmd_t;
  // ==========================================================
  // Reported breaker position
  typedef enum logic [1:0] {
    POS_INTER = 2'h0,
    POS_OPEN = 2'h1,
    POS_CLOSED = 2'h2,
    POS_BAD = 2'h3
  } bow_pos_t;
endpackage

/* logic/bow_regs.svh */
// Register offsets, field positions, reset values and timing counts of the breaker monitor
`ifndef BOW_REGS_SVH
`define BOW_REGS_SVH
// ==========================================================
// Time base
`define BOW_CLK_HZ 20000000
`define BOW_STEP_MS 20
`define BOW_TICK_CYCLES (`BOW_CLK_HZ / 1000 * `BOW_STEP_MS)
// ==========================================================
// Register byte offsets
`define BOW_OFS_CTRL 7'h00
`define BOW_OFS_TRAV 7'h04
`define BOW_OFS_CPULSE 7'h08
`define BOW_OFS_OPULSE 7'h0C
`define BOW_OFS_TERM 7'h10
`define BOW_OFS_FTPULSE 7'h14
`define BOW_OFS_START 7'h18
`define BOW_OFS_LIM1 7'h1C
`define BOW_OFS_LIM2 7'h20
`define BOW_OFS_CUR1 7'h24
`define BOW_OFS_CUR2 7'h28
`define BOW_OFS_WHIGH 7'h2C
`define BOW_OFS_SLOPE 7'h30
`define BOW_OFS_STAT 7'h34
`define BOW_OFS_IRQST 7'h38
`define BOW_OFS_IRQMSK 7'h3C
`define BOW_OFS_LEFTA 7'h40
`define BOW_OFS_LEFTB 7'h44
`define BOW_OFS_LEFTC 7'h48
// ==========================================================
// Control fields
`define BOW_CTRL_WEAR_EN 0
`define BOW_CTRL_MODSEL 1
`define BOW_CTRL_TRIPSEL 2
`define BOW_CTRL_AL1_EN 3
`define BOW_CTRL_AL2_EN 4
`define BOW_CTRL_ACC_LO 5
`define BOW_CTRL_RELOAD 7
// ==========================================================
// Event bits
`define BOW_EV_POS 0
`define BOW_EV_FAIL 1
`define BOW_EV_BLOCK 2
`define BOW_EV_AL1 3
`define BOW_EV_AL2 4
`define BOW_EV_FT 5
`define BOW_EV_W 6
// ==========================================================
// Reset values, delays in 20 ms steps, currents in 10 A units
`define BOW_RST_CTRL 8'h40
`define BOW_RST_TRAV 16'h000A
`define BOW_RST_PULSE 16'h000A
`define BOW_RST_TERM 16'h01F4
`define BOW_RST_FTPULSE 16'h000A
`define BOW_RST_START 32'h0000_C350
`define BOW_RST_LIM1 32'h0000_03E8
`define BOW_RST_LIM2 32'h0000_0064
`define BOW_RST_CUR1 16'h0064
`define BOW_RST_CUR2 16'h07D0
`define BOW_RST_WHIGH 32'h0000_01F4
`define BOW_RST_SLOPE 16'h0100
`endif

/* logic/bow_top.sv */
// Breaker object control with traverse supervision, final trip and wear monitor
//
// The register addresses and the strobed register port are this design's own decisions.
`include "bow_regs.svh"
// Behaviour
// - Traverse time expired with both status inputs high reports position bad.
// - Traverse time expired with neither status input high reports intermediate.
// - Close pulse limited to its setting, ends early once the breaker is closed.
// - Open pulse limited to its own setting, ends early once the breaker is open.
// - No state change within termination timeout raises error event, ends control.
// - Final trip signal pulses for its set length after a final trip.
// - Final trip length zero holds the final trip signal until a close command starts.
// - Final trip only when no automatic reclose is pending.
// - Panel control accepted only at or above the required access level.
// - Open and close accepted from local, remote and application inputs.
// - Open and close have separate blocking inputs.
// - Wear evaluation starts when the selected trip output rises, sampling currents.
// - Per phase consumed operations are subtracted from the starting count.
// - Two alarms fire when remaining operations fall below their limits.
// - Wear uses phase RMS currents refreshed on a 5 ms time base.
// - Wear monitor runs only when enabled; module one or two selected.
// - Open status high means open, close status high means closed.
module bow_top import bow_pkg::*; #(
  parameter int TICK_CYCLES = `BOW_TICK_CYCLES,
  parameter int CW = 16
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [6:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic OPEN_STATUS,
  input wire logic CLOSE_STATUS,
  input wire logic LOCAL_OPEN,
  input wire logic LOCAL_CLOSE,
  input wire logic REMOTE_OPEN,
  input wire logic REMOTE_CLOSE,
  input wire logic APP_OPEN,
  input wire logic APP_CLOSE,
  input wire logic PANEL_OPEN,
  input wire logic PANEL_CLOSE,
  input wire logic [1:0] PANEL_LEVEL,
  input wire logic TRIP_OPEN,
  input wire logic AR_RECLOSE_PENDING,
  input wire logic OPEN_BLOCK,
  input wire logic CLOSE_BLOCK,
  input wire logic [CW-1:0] M1_PHASE_A_RMS_CURRENT,
  input wire logic [CW-1:0] M1_PHASE_B_RMS_CURRENT,
  input wire logic [CW-1:0] M1_PHASE_C_RMS_CURRENT,
  input wire logic [CW-1:0] M2_PHASE_A_RMS_CURRENT,
  input wire logic [CW-1:0] M2_PHASE_B_RMS_CURRENT,
  input wire logic [CW-1:0] M2_PHASE_C_RMS_CURRENT,
  output logic OPEN_CMD,
  output logic CLOSE_CMD,
  output logic FINAL_TRIP,
  output logic ALARM1,
  output logic ALARM2,
  output logic [1:0] POSITION,
  output logic IRQ
);
  // ==========================================================
  // Registers
  logic [7:0] ctrl_reg;
  logic [15:0] trav_reg, cpulse_reg, opulse_reg, term_reg, ftpulse_reg;
  logic [31:0] start_reg, lim1_reg, lim2_reg, whigh_reg;
  logic [15:0] cur1_reg, cur2_reg, slope_reg;
  logic [6:0] irq_st_reg, irq_msk_reg, irq_st_next, ev;
  logic [31:0] rdata_next;
  logic [31:0] left_reg [3];
  wire wr_ctrl = WR && ADDR == `BOW_OFS_CTRL;
  wire rd_irq = RD && ADDR == `BOW_OFS_IRQST;
  wire wear_en = ctrl_reg[`BOW_CTRL_WEAR_EN];
  wire [1:0] acc_req = ctrl_reg[`BOW_CTRL_ACC_LO +: 2];

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ctrl_reg <= `BOW_RST_CTRL;
      trav_reg <= `BOW_RST_TRAV;
      cpulse_reg <= `BOW_RST_PULSE;
      opulse_reg <= `BOW_RST_PULSE;
      term_reg <= `BOW_RST_TERM;
      ftpulse_reg <= `BOW_RST_FTPULSE;
      start_reg <= `BOW_RST_START;
      lim1_reg <= `BOW_RST_LIM1;
      lim2_reg <= `BOW_RST_LIM2;
      cur1_reg <= `BOW_RST_CUR1;
      cur2_reg <= `BOW_RST_CUR2;
      whigh_reg <= `BOW_RST_WHIGH;
      slope_reg <= `BOW_RST_SLOPE;
      irq_msk_reg <= 7'h00;
    end else if (WR) begin
      case (ADDR)
        `BOW_OFS_CTRL: ctrl_reg <= {1'b0, WDATA[6:0]};
        `BOW_OFS_TRAV: trav_reg <= WDATA[15:0];
        `BOW_OFS_CPULSE: cpulse_reg <= WDATA[15:0];
        `BOW_OFS_OPULSE: opulse_reg <= WDATA[15:0];
        `BOW_OFS_TERM: term_reg <= WDATA[15:0];
        `BOW_OFS_FTPULSE: ftpulse_reg <= WDATA[15:0];
        `BOW_OFS_START: start_reg <= WDATA;
        `BOW_OFS_LIM1: lim1_reg <= WDATA;
        `BOW_OFS_LIM2: lim2_reg <= WDATA;
        `BOW_OFS_CUR1: cur1_reg <= WDATA[15:0];
        `BOW_OFS_CUR2: cur2_reg <= WDATA[15:0];
        `BOW_OFS_WHIGH: whigh_reg <= WDATA;
        `BOW_OFS_SLOPE: slope_reg <= WDATA[15:0];
        `BOW_OFS_IRQMSK: irq_msk_reg <= WDATA[6:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Common tick
  logic [31:0] div_reg;
  logic tick_reg;
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      div_reg <= 32'h0000_0000;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= div_reg == 32'(TICK_CYCLES - 1);
      div_reg <= (div_reg == 32'(TICK_CYCLES - 1)) ? 32'h0000_0000 : div_reg + 32'h0000_0001;
    end
  end

  // ==========================================================
  // Position and traverse timer
  logic [1:0] pair_reg;
  logic [15:0] trav_cnt_reg;
  bow_pos_t pos_reg, pos_next;
  wire [1:0] pair = {CLOSE_STATUS, OPEN_STATUS};
  wire trav_exp = pair == pair_reg && trav_cnt_reg >= trav_reg;
  wire is_open = OPEN_STATUS && !CLOSE_STATUS;
  wire is_closed = CLOSE_STATUS && !OPEN_STATUS;
  assign pos_next = is_open ? POS_OPEN : is_closed ? POS_CLOSED :
    !trav_exp ? pos_reg : (OPEN_STATUS ? POS_BAD : POS_INTER);
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      pair_reg <= 2'h0;
      trav_cnt_reg <= 16'h0000;
      pos_reg <= POS_INTER;
    end else begin
      pair_reg <= pair;
      pos_reg <= pos_next;
      if (pair != pair_reg) trav_cnt_reg <= 16'h0000;
      else if (tick_reg && !trav_exp) trav_cnt_reg <= trav_cnt_reg + 16'h0001;
    end
  end

  // ==========================================================
  // Requests and interlocks
  logic [3:0] oreq_d_reg, creq_d_reg;
  logic trip_d_reg;
  wire acc_ok = PANEL_LEVEL >= acc_req;
  wire [3:0] oreq = {PANEL_OPEN && acc_ok, APP_OPEN, REMOTE_OPEN, LOCAL_OPEN};
  wire [3:0] creq = {PANEL_CLOSE && acc_ok, APP_CLOSE, REMOTE_CLOSE, LOCAL_CLOSE};
  wire trip_rise = TRIP_OPEN && !trip_d_reg;
  wire open_rise = |(oreq & ~oreq_d_reg) || trip_rise;
  wire close_rise = |(creq & ~creq_d_reg);
  bow_cmd_t st_reg, st_next;
  wire idle = st_reg == CS_IDLE;
  wire start_open = idle && open_rise && !OPEN_BLOCK;
  wire start_close = idle && !open_rise && close_rise && !CLOSE_BLOCK;
  wire blocked = idle && ((open_rise && OPEN_BLOCK) || (!open_rise && close_rise && CLOSE_BLOCK));

  // ==========================================================
  // Command sequencer
  logic [15:0] pulse_cnt_reg, term_cnt_reg;
  logic dir_open_reg, trip_flag_reg;
  wire reached = dir_open_reg ? is_open : is_closed;
  wire [15:0] plen = dir_open_reg ? opulse_reg : cpulse_reg;
  wire pulse_hit = tick_reg && pulse_cnt_reg + 16'h0001 >= plen;
  wire term_hit = tick_reg && term_cnt_reg + 16'h0001 >= term_reg;
  wire busy = !idle;
  wire fail = busy && !reached && term_hit;
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      CS_IDLE: begin
        if (start_open) st_next = CS_OPEN;
        else if (start_close) st_next = CS_CLOSE;
      end
      CS_OPEN, CS_CLOSE: begin
        if (reached || term_hit) st_next = CS_IDLE;
        else if (pulse_hit) st_next = CS_WAIT;
      end
      CS_WAIT: begin
        if (reached || term_hit) st_next = CS_IDLE;
      end
      default: st_next = CS_IDLE;
    endcase
  end
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      st_reg <= CS_IDLE;
      oreq_d_reg <= 4'h0;
      creq_d_reg <= 4'h0;
      trip_d_reg <= 1'b0;
      pulse_cnt_reg <= 16'h0000;
      term_cnt_reg <= 16'h0000;
      dir_open_reg <= 1'b0;
      trip_flag_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      oreq_d_reg <= oreq;
      creq_d_reg <= creq;
      trip_d_reg <= TRIP_OPEN;
      if (idle) begin
        pulse_cnt_reg <= 16'h0000;
        term_cnt_reg <= 16'h0000;
        dir_open_reg <= start_open;
        trip_flag_reg <= start_open && TRIP_OPEN;
      end else if (tick_reg) begin
        pulse_cnt_reg <= pulse_cnt_reg + 16'h0001;
        term_cnt_reg <= term_cnt_reg + 16'h0001;
      end
    end
  end

  // ==========================================================
  // Final trip
  logic ft_reg;
  logic [15:0] ft_cnt_reg;
  wire ft_start = busy && dir_open_reg && trip_flag_reg && is_open && !AR_RECLOSE_PENDING;
  wire ft_end = ftpulse_reg != 16'h0000 && tick_reg && ft_cnt_reg + 16'h0001 >= ftpulse_reg;
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ft_reg <= 1'b0;
      ft_cnt_reg <= 16'h0000;
    end else if (ft_start) begin
      ft_reg <= 1'b1;
      ft_cnt_reg <= 16'h0000;
    end else if (start_close || (ft_reg && ft_end)) begin
      ft_reg <= 1'b0;
    end else if (ft_reg && tick_reg) begin
      ft_cnt_reg <= ft_cnt_reg + 16'h0001;
    end
  end

  // ==========================================================
  // Wear monitor
  logic trig_d_reg, al1_reg, al2_reg;
  wire trig_src = ctrl_reg[`BOW_CTRL_TRIPSEL] ? ft_reg : st_reg == CS_OPEN;
  wire wear_trig = wear_en && trig_src && !trig_d_reg;
  wire reload = wr_ctrl && WDATA[`BOW_CTRL_RELOAD];
  wire [CW-1:0] cur [3];
  logic [2:0] below1, below2;
  assign cur[0] = ctrl_reg[`BOW_CTRL_MODSEL] ? M2_PHASE_A_RMS_CURRENT : M1_PHASE_A_RMS_CURRENT;
  assign cur[1] = ctrl_reg[`BOW_CTRL_MODSEL] ? M2_PHASE_B_RMS_CURRENT : M1_PHASE_B_RMS_CURRENT;
  assign cur[2] = ctrl_reg[`BOW_CTRL_MODSEL] ? M2_PHASE_C_RMS_CURRENT : M1_PHASE_C_RMS_CURRENT;
  for (genvar p = 0; p < 3; p++) begin : g_phase
    wire [31:0] dif = {{(32-CW){1'b0}}, cur[p]} - {16'h0000, cur1_reg};
    wire [47:0] prod = 48'(dif) * 48'(slope_reg);
    wire [31:0] lin = 32'h0000_0001 + prod[39:8];
    wire [31:0] ded = (cur[p] <= cur1_reg) ? 32'h0000_0001 :
      (cur[p] >= cur2_reg || lin > whigh_reg) ? whigh_reg : lin;
    assign below1[p] = left_reg[p] < lim1_reg;
    assign below2[p] = left_reg[p] < lim2_reg;
    always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) left_reg[p] <= `BOW_RST_START;
      else if (reload) left_reg[p] <= start_reg;
      else if (wear_trig) left_reg[p] <= (left_reg[p] > ded) ? left_reg[p] - ded : 32'h0000_0000;
    end
  end
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      trig_d_reg <= 1'b0;
      al1_reg <= 1'b0;
      al2_reg <= 1'b0;
    end else begin
      trig_d_reg <= trig_src;
      al1_reg <= wear_en && ctrl_reg[`BOW_CTRL_AL1_EN] && |below1;
      al2_reg <= wear_en && ctrl_reg[`BOW_CTRL_AL2_EN] && |below2;
    end
  end

  // ==========================================================
  // Events, interrupt and read back
  logic irq_reg;
  logic [31:0] rdata_reg;
  wire [31:0] stat_w = {23'h0, al2_reg, al1_reg, ft_reg, st_reg, pos_reg};
  assign ev = {wear_trig, ft_start && !ft_reg, |below2 && !al2_reg && al2_reg != 1'b1 &&
    wear_en && ctrl_reg[`BOW_CTRL_AL2_EN], |below1 && !al1_reg && wear_en &&
    ctrl_reg[`BOW_CTRL_AL1_EN], blocked, fail, pos_next != pos_reg};
  assign irq_st_next = (rd_irq ? 7'h00 : irq_st_reg) | ev;
  always_comb begin
    case (ADDR)
      `BOW_OFS_CTRL: rdata_next = {24'h0, ctrl_reg};
      `BOW_OFS_TRAV: rdata_next = {16'h0, trav_reg};
      `BOW_OFS_CPULSE: rdata_next = {16'h0, cpulse_reg};
      `BOW_OFS_OPULSE: rdata_next = {16'h0, opulse_reg};
      `BOW_OFS_TERM: rdata_next = {16'h0, term_reg};
      `BOW_OFS_FTPULSE: rdata_next = {16'h0, ftpulse_reg};
      `BOW_OFS_START: rdata_next = start_reg;
      `BOW_OFS_LIM1: rdata_next = lim1_reg;
      `BOW_OFS_LIM2: rdata_next = lim2_reg;
      `BOW_OFS_CUR1: rdata_next = {16'h0, cur1_reg};
      `BOW_OFS_CUR2: rdata_next = {16'h0, cur2_reg};
      `BOW_OFS_WHIGH: rdata_next = whigh_reg;
      `BOW_OFS_SLOPE: rdata_next = {16'h0, slope_reg};
      `BOW_OFS_STAT: rdata_next = stat_w;
      `BOW_OFS_IRQST: rdata_next = {25'h0, irq_st_reg};
      `BOW_OFS_IRQMSK: rdata_next = {25'h0, irq_msk_reg};
      `BOW_OFS_LEFTA: rdata_next = left_reg[0];
      `BOW_OFS_LEFTB: rdata_next = left_reg[1];
      `BOW_OFS_LEFTC: rdata_next = left_reg[2];
      default: rdata_next = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      irq_st_reg <= 7'h00;
      irq_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      irq_st_reg <= irq_st_next;
      irq_reg <= |(irq_st_next & irq_msk_reg);
      rdata_reg <= RD ? rdata_next : 32'h0000_0000;
    end
  end
  assign RDATA = rdata_reg;
  assign OPEN_CMD = st_reg[1];
  assign CLOSE_CMD = st_reg[2];
  assign FINAL_TRIP = ft_reg;
  assign ALARM1 = al1_reg;
  assign ALARM2 = al2_reg;
  assign POSITION = pos_reg;
  assign IRQ = irq_reg;

  // ==========================================================
  // Assertions
  AST_BAD_POS: assert property (@(posedge CLOCK) disable iff (RST)
    (trav_exp && OPEN_STATUS && CLOSE_STATUS) |=> POSITION == POS_BAD)
    else $error("bad position not reported");
  AST_INTER_POS: assert property (@(posedge CLOCK) disable iff (RST)
    (trav_exp && !OPEN_STATUS && !CLOSE_STATUS) |=> POSITION == POS_INTER)
    else $error("intermediate position not reported");
  AST_CLOSE_EARLY: assert property (@(posedge CLOCK) disable iff (RST)
    (CLOSE_CMD && is_closed) |=> !CLOSE_CMD && !OPEN_CMD)
    else $error("close pulse not ended on closed");
  AST_OPEN_LIMIT: assert property (@(posedge CLOCK) disable iff (RST)
    (OPEN_CMD && pulse_hit && !reached && !term_hit) |=> !OPEN_CMD && st_reg == CS_WAIT)
    else $error("open pulse exceeded its length");
  AST_TERM_FAIL: assert property (@(posedge CLOCK) disable iff (RST)
    (st_reg == CS_WAIT && !reached && term_hit && !rd_irq)
    |=> st_reg == CS_IDLE && irq_st_reg[`BOW_EV_FAIL])
    else $error("termination timeout not handled");
  AST_FT_HOLD: assert property (@(posedge CLOCK) disable iff (RST)
    (FINAL_TRIP && ftpulse_reg == 16'h0000 && !start_close) |=> FINAL_TRIP)
    else $error("continuous final trip dropped");
  AST_FT_AR: assert property (@(posedge CLOCK) disable iff (RST)
    $rose(FINAL_TRIP) |-> $past(!AR_RECLOSE_PENDING))
    else $error("final trip with reclose pending");
  AST_ACCESS: assert property (@(posedge CLOCK) disable iff (RST)
    (idle && PANEL_OPEN && PANEL_LEVEL < acc_req && oreq[2:0] == oreq_d_reg[2:0]
    && !close_rise && !trip_rise) |=> st_reg == CS_IDLE)
    else $error("panel command below access level");
  AST_BLOCK: assert property (@(posedge CLOCK) disable iff (RST)
    (idle && open_rise && OPEN_BLOCK) |=> !OPEN_CMD && irq_st_reg[`BOW_EV_BLOCK])
    else $error("blocked open executed");
  AST_WEAR_OFF: assert property (@(posedge CLOCK) disable iff (RST)
    (!wear_en && !reload) |=> $stable(left_reg[0]) && !ALARM1)
    else $error("wear monitor active while disabled");
  AST_ALARM2: assert property (@(posedge CLOCK) disable iff (RST)
    (wear_en && ctrl_reg[`BOW_CTRL_AL2_EN] && below2[1]) |=> ALARM2)
    else $error("alarm 2 missing");
  COV_CLOSE: cover property (@(posedge CLOCK) disable iff (RST) $rose(CLOSE_CMD) ##[1:50] is_closed);
  COV_FT: cover property (@(posedge CLOCK) disable iff (RST) $rose(FINAL_TRIP));
  COV_FAIL: cover property (@(posedge CLOCK) disable iff (RST) fail);
  COV_WEAR: cover property (@(posedge CLOCK) disable iff (RST) wear_trig ##1 $rose(ALARM1));
endmodule

/* verification/bow_breaker_model.sv */
// Breaker contact model that answers the command relays
module bow_breaker_model #(
  parameter int D = 10
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic open_cmd,
  input wire logic close_cmd,
  input wire logic stuck,
  input wire logic ovr_en,
  input wire logic [1:0] ovr_val,
  output logic open_status,
  output logic close_status
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Contact travel: old contact leaves, then new contact makes
  int cnt;
  logic tgt_open, moving, op_reg, cl_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      op_reg <= 1'h0;
      cl_reg <= 1'h1;
      moving <= 1'h0;
      cnt <= 0;
      tgt_open <= 1'h0;
    end else if (!moving) begin
      if (!stuck && ((open_cmd && !op_reg) || (close_cmd && !cl_reg))) begin
        moving <= 1'h1;
        tgt_open <= open_cmd;
        cnt <= 0;
      end
    end else begin
      cnt <= cnt + 1;
      if (cnt == D) begin
        if (tgt_open) cl_reg <= 1'h0;
        else op_reg <= 1'h0;
      end
      if (cnt == 2 * D) begin
        if (tgt_open) op_reg <= 1'h1;
        else cl_reg <= 1'h1;
        moving <= 1'h0;
      end
    end
  end
  assign open_status = ovr_en ? ovr_val[0] : op_reg;
  assign close_status = ovr_en ? ovr_val[1] : cl_reg;
endmodule

/* verification/bow_top_bench.sv */
// Self-checking bench for the breaker object control and wear monitor
`include "bow_regs.svh"
module bow_top_bench import bow_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0, rst = 1'h1, wr_s = 1'h0, rd_s = 1'h0, trip = 1'h0, ar = 1'h0;
  logic ob = 1'h0, cb = 1'h0, stuck = 1'h0, oe = 1'h0;
  logic [1:0] ov = 2'h0, lvl = 2'h2, pos;
  logic [6:0] addr = 7'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, r;
  logic [7:0] req = 8'h00;
  logic [15:0] ia = 16'h0000, ib = 16'h0000, ic = 16'h0000;
  logic ocmd, ccmd, ft, al1, al2, irq, os, cs;
  int failures = 0, num_checks = 0;
  always #25 clk = ~clk;
  bow_top #(.TICK_CYCLES(20)) dut_u (.CLOCK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata),
    .WR(wr_s), .RD(rd_s), .RDATA(rdata), .OPEN_STATUS(os), .CLOSE_STATUS(cs),
    .LOCAL_OPEN(req[0]), .LOCAL_CLOSE(req[1]), .REMOTE_OPEN(req[2]), .REMOTE_CLOSE(req[3]),
    .APP_OPEN(req[4]), .APP_CLOSE(req[5]), .PANEL_OPEN(req[6]), .PANEL_CLOSE(req[7]),
    .PANEL_LEVEL(lvl), .TRIP_OPEN(trip), .AR_RECLOSE_PENDING(ar), .OPEN_BLOCK(ob),
    .CLOSE_BLOCK(cb), .M1_PHASE_A_RMS_CURRENT(ia), .M1_PHASE_B_RMS_CURRENT(ib),
    .M1_PHASE_C_RMS_CURRENT(ic), .M2_PHASE_A_RMS_CURRENT(ib), .M2_PHASE_B_RMS_CURRENT(ic),
    .M2_PHASE_C_RMS_CURRENT(ia), .OPEN_CMD(ocmd), .CLOSE_CMD(ccmd), .FINAL_TRIP(ft),
    .ALARM1(al1), .ALARM2(al2), .POSITION(pos), .IRQ(irq));
  bow_breaker_model bm_u (.clk(clk), .rst(rst), .open_cmd(ocmd), .close_cmd(ccmd),
    .stuck(stuck), .ovr_en(oe), .ovr_val(ov), .open_status(os), .close_status(cs));
  // ==========================================================
  // Shared tasks
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'h1;
    @(posedge clk);
    wr_s <= 1'h0;
  endtask
  task automatic rd(input logic [6:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'h1;
    @(posedge clk);
    rd_s <= 1'h0;
    #1 d = rdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    req[i] <= 1'h1;
    @(posedge clk);
    req[i] <= 1'h0;
    #1;
  endtask
  task automatic waitpos(input bow_pos_t p);
    for (int k = 0; k < 300 && pos !== p; k++) cyc(1);
    chk("position", {30'h0, p}, {30'h0, pos});
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs;
    rd(`BOW_OFS_CTRL, r);
    chk("ctrl", 32'h0000_0040, r);
    rd(`BOW_OFS_TRAV, r);
    chk("trav", 32'h0000_000A, r);
    rd(`BOW_OFS_TERM, r);
    chk("term", 32'h0000_01F4, r);
    rd(7'h7C, r);
    chk("unmapped", 32'h0000_0000, r);
    wr(`BOW_OFS_TERM, 32'h0000_000F);
    rd(`BOW_OFS_IRQST, r);
    $display("regs done");
  endtask
  task automatic t_block;
    wr(`BOW_OFS_IRQMSK, 32'h0000_0004);
    ob <= 1'h1;
    cyc(10);
    pulse(4);
    chk("blocked open", 32'h0, {31'h0, ocmd});
    cyc(2);
    chk("irq", 32'h1, {31'h0, irq});
    rd(`BOW_OFS_IRQST, r);
    chk("irq status", 32'h0000_0004, r);
    cyc(1);
    chk("irq cleared", 32'h0, {31'h0, irq});
    ob <= 1'h0;
    $display("block done");
  endtask
  task automatic t_open;
    pulse(0);
    chk("open cmd", 32'h1, {31'h0, ocmd});
    waitpos(POS_OPEN);
    cyc(1);
    chk("open cmd end", 32'h0, {31'h0, ocmd});
    lvl <= 2'h1;
    pulse(6);
    chk("panel open low", 32'h0, {31'h0, ocmd});
    pulse(7);
    chk("panel low", 32'h0, {31'h0, ccmd});
    lvl <= 2'h2;
    cb <= 1'h1;
    cyc(10);
    pulse(7);
    chk("blocked close", 32'h0, {31'h0, ccmd});
    cb <= 1'h0;
    cyc(10);
    pulse(7);
    chk("panel close", 32'h1, {31'h0, ccmd});
    waitpos(POS_CLOSED);
    cyc(1);
    chk("close cmd end", 32'h0, {31'h0, ccmd});
    $display("open close done");
  endtask
  task automatic t_stuck;
    stuck <= 1'h1;
    rd(`BOW_OFS_IRQST, r);
    pulse(2);
    cyc(170);
    chk("pulse held", 32'h1, {31'h0, ocmd});
    cyc(60);
    chk("pulse limit", 32'h0, {31'h0, ocmd});
    cyc(100);
    rd(`BOW_OFS_IRQST, r);
    chk("fail event", 32'h0000_0002, r & 32'h0000_0002);
    rd(`BOW_OFS_STAT, r);
    chk("idle closed", 32'h0000_0006, r & 32'h0000_003F);
    stuck <= 1'h0;
    oe <= 1'h1;
    ov <= 2'h3;
    cyc(150);
    chk("pos hold", {30'h0, POS_CLOSED}, {30'h0, pos});
    cyc(80);
    chk("pos bad", {30'h0, POS_BAD}, {30'h0, pos});
    ov <= 2'h0;
    cyc(230);
    chk("pos inter", {30'h0, POS_INTER}, {30'h0, pos});
    oe <= 1'h0;
    waitpos(POS_CLOSED);
    $display("timeouts done");
  endtask
  task automatic t_ftrip;
    for (int k = 0; k < 3; k++) begin
      if (k == 1) ar <= 1'h1;
      if (k == 2) wr(`BOW_OFS_FTPULSE, 32'h0000_0000);
      trip <= 1'h1;
      waitpos(POS_OPEN);
      cyc(2);
      chk("final trip", {31'h0, k != 1}, {31'h0, ft});
      cyc(230);
      chk("final trip end", {31'h0, k == 2}, {31'h0, ft});
      trip <= 1'h0;
      ar <= 1'h0;
      pulse(3);
      waitpos(POS_CLOSED);
    end
    $display("final trip done");
  endtask
  task automatic t_wear;
    rd(`BOW_OFS_LEFTA, r);
    chk("left idle", 32'h0000_C350, r);
    ia <= 16'h0064;
    ib <= 16'h07D0;
    ic <= 16'h012C;
    wr(`BOW_OFS_LIM1, 32'h0000_C350);
    wr(`BOW_OFS_CTRL, 32'h0000_0049);
    pulse(4);
    waitpos(POS_OPEN);
    cyc(2);
    rd(`BOW_OFS_LEFTA, r);
    chk("left a", 32'h0000_C34F, r);
    rd(`BOW_OFS_LEFTB, r);
    chk("left b", 32'h0000_C15C, r);
    rd(`BOW_OFS_LEFTC, r);
    chk("left c", 32'h0000_C287, r);
    chk("alarm1", 32'h1, {31'h0, al1});
    chk("alarm2", 32'h0, {31'h0, al2});
    pulse(3);
    waitpos(POS_CLOSED);
    wr(`BOW_OFS_LIM2, 32'h0000_C350);
    wr(`BOW_OFS_CTRL, 32'h0000_0057);
    trip <= 1'h1;
    waitpos(POS_OPEN);
    cyc(2);
    rd(`BOW_OFS_LEFTA, r);
    chk("left a module two", 32'h0000_C15B, r);
    chk("alarm2 on", 32'h1, {31'h0, al2});
    chk("alarm1 disabled", 32'h0, {31'h0, al1});
    trip <= 1'h0;
    wr(`BOW_OFS_CTRL, 32'h0000_00C0);
    rd(`BOW_OFS_LEFTA, r);
    chk("left reload", 32'h0000_C350, r);
    $display("wear done");
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    t_regs();
    t_block();
    t_open();
    t_stuck();
    t_ftrip();
    t_wear();
    conclude();
  end
  initial begin
    #(50 * 20000);
    failures++;
    conclude();
  end
endmodule
